// [design/dmld_pkg.sv]
// Purpose: Shared constants and types for the dot-matrix LCD driver.
// Assumes: Display memory offsets are counted from the start of display RAM.
// Notes:   Drive levels are digital codes for the five 1/4 bias voltages.
package dmld_pkg;

  // ----------------------------------------------------------------
  // Panel geometry.
  // ----------------------------------------------------------------
  localparam int NUM_COM = 17;
  localparam int NUM_SEG = 60;

  // ----------------------------------------------------------------
  // Drive level codes, VSS up to the top bias level.
  // ----------------------------------------------------------------
  typedef logic [2:0] dmld_level_t;
  localparam dmld_level_t LVL_V0 = 3'h0;
  localparam dmld_level_t LVL_V1 = 3'h1;
  localparam dmld_level_t LVL_V2 = 3'h2;
  localparam dmld_level_t LVL_V3 = 3'h3;
  localparam dmld_level_t LVL_V4 = 3'h4;

  // ----------------------------------------------------------------
  // Scan timing, counted in low-speed oscillator periods.
  // ----------------------------------------------------------------
  localparam int OSC_HZ          = 32768;
  localparam int FRAME_HZ_8_16   = 32;
  localparam int COM_TICKS_WIDE  = OSC_HZ / (FRAME_HZ_8_16 * 16);
  localparam int COM_TICKS_EIGHT = OSC_HZ / (FRAME_HZ_8_16 * 8);
  localparam int LAST_COM_8      = 7;
  localparam int LAST_COM_16     = 15;
  localparam int LAST_COM_17     = 16;

  // ----------------------------------------------------------------
  // Display memory map: page in offset bits 11:8, index in 7:0.
  // ----------------------------------------------------------------
  localparam logic [3:0] PAGE_LOW   = 4'h0;
  localparam logic [3:0] PAGE_HIGH  = 4'h1;
  localparam logic [3:0] PAGE_COM16 = 4'h2;
  localparam logic [7:0] PAGE_WORDS = 8'h78;
  localparam logic [7:0] COM16_LAST = 8'h76;

  // ----------------------------------------------------------------
  // Control values after reset.
  // ----------------------------------------------------------------
  localparam logic       RST_POWER    = 1'b0;
  localparam logic       RST_ALL_ON   = 1'b0;
  localparam logic       RST_ALL_OFF  = 1'b1;
  localparam logic [1:0] RST_DUTY     = 2'h0;
  localparam logic       RST_PAGE     = 1'b0;
  localparam logic [3:0] RST_CONTRAST = 4'h0;

endpackage

// [design/dmld_scan_timer.sv]
// Purpose: Turns the low-speed oscillator pin into common-step pulses.
// Assumes: The oscillator is far slower than core_clk.
// Notes:   One step pulse marks the start of each common period.
`timescale 1ns/1ps

module dmld_scan_timer
  import dmld_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic low_speed_oscillator,
  input  wire logic eighth_duty,
  output logic      com_step
);

  logic       osc_s1_q;
  logic       osc_s2_q;
  logic       osc_prev_q;
  logic       osc_tick;
  logic [7:0] tick_cnt_q;
  logic [7:0] tick_last;

  // ----------------------------------------------------------------
  // Pin synchroniser; only the second stage feeds the edge detector.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      osc_s1_q   <= 1'b0;
      osc_s2_q   <= 1'b0;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      osc_s1_q   <= low_speed_oscillator;
      osc_s2_q   <= osc_s1_q;
      osc_prev_q <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q & ~osc_prev_q;

  // Frame rate divider.
  // A common lasts 128 ticks at 1/8 and 64 otherwise, so 1/17 is 30.12 Hz.
  assign tick_last = eighth_duty ? 8'(COM_TICKS_EIGHT - 1) : 8'(COM_TICKS_WIDE - 1);

  // Counter of oscillator edges; a duty change applies at once to the common already in progress.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tick_cnt_q <= 8'h00;
      com_step   <= 1'b0;
    end
    else
    begin
      com_step <= 1'b0;
      if (osc_tick)
      begin
        if (tick_cnt_q >= tick_last)
        begin
          tick_cnt_q <= 8'h00;
          com_step   <= 1'b1;
        end
        else
        begin
          tick_cnt_q <= tick_cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // dmld_scan_timer

// [design/dmld_core.sv]
// Purpose: Dot-matrix LCD driver: control bits, display memory and scan.
// Assumes: CPU side is a simple strobed port on core_clk.
// Notes:   Outputs are level codes; analog switching lies outside.
`timescale 1ns/1ps

module dmld_core
  import dmld_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  low_speed_oscillator,
  input  wire logic                  ctrl_write,
  input  wire logic                  drive_power_enable,
  input  wire logic                  all_dots_on,
  input  wire logic                  all_dots_off,
  input  wire logic                  duty_select_hi,
  input  wire logic                  duty_select_lo,
  input  wire logic                  display_page_select,
  input  wire logic [3:0]            contrast_code,
  output logic                       drive_power_enable_rd,
  output logic                       all_dots_on_rd,
  output logic                       all_dots_off_rd,
  output logic [1:0]                 duty_select_rd,
  output logic                       display_page_select_rd,
  output logic [3:0]                 contrast_code_rd,
  input  wire logic [11:0]           mem_addr,
  input  wire logic                  mem_wr,
  input  wire logic                  mem_rd,
  input  wire logic [3:0]            mem_wdata,
  output logic [3:0]                 mem_rdata,
  output logic                       drive_gen_on,
  output logic [6:0]                 level_vc1,
  output logic [6:0]                 reference_drive_level,
  output logic [6:0]                 level_vc4,
  output logic [6:0]                 level_vc5,
  output dmld_level_t [NUM_COM-1:0]  common_outputs,
  output dmld_level_t [NUM_SEG-1:0]  segment_outputs
);

  logic                   com_step;
  logic [4:0]             com_q;
  logic                   pol_q;
  logic [4:0]             last_com;
  logic                   eighth;
  logic [3:0]             low_q   [0:119];
  logic [3:0]             high_q  [0:119];
  logic                   c16_q   [0:NUM_SEG-1];
  logic [3:0]             pg;
  logic [7:0]             idx;
  logic                   hit_row;
  logic                   hit_c16;
  logic [NUM_SEG-1:0]     dot;
  dmld_level_t            com_sel;
  dmld_level_t            com_idle;
  dmld_level_t            seg_on;
  dmld_level_t            seg_off;
  logic [6:0]             unit;

  // ----------------------------------------------------------------
  // Control bits.
  // ----------------------------------------------------------------

  // Reset values.
  // The display starts blanked and unpowered until software sets it up.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      drive_power_enable_rd  <= RST_POWER;
      all_dots_on_rd         <= RST_ALL_ON;
      all_dots_off_rd        <= RST_ALL_OFF;
      duty_select_rd         <= RST_DUTY;
      display_page_select_rd <= RST_PAGE;
      contrast_code_rd       <= RST_CONTRAST;
    end
    else if (ctrl_write)
    begin
      drive_power_enable_rd  <= drive_power_enable;
      all_dots_on_rd         <= all_dots_on;
      all_dots_off_rd        <= all_dots_off;
      duty_select_rd         <= {duty_select_hi, duty_select_lo};
      display_page_select_rd <= display_page_select;
      contrast_code_rd       <= contrast_code;
    end
  end

  // Duty decode.
  // The low duty bit is ignored whenever the high bit selects 1/8.
  assign eighth   = duty_select_rd[1];
  assign last_com = eighth ? 5'(LAST_COM_8) :
                    duty_select_rd[0] ? 5'(LAST_COM_16) : 5'(LAST_COM_17);

  // ----------------------------------------------------------------
  // Display memory.
  // ----------------------------------------------------------------

  // Address decode.
  // Page 0 and 1 hold 120 nibbles; page 2 holds one bit at even indexes.
  assign pg      = mem_addr[11:8];
  assign idx     = mem_addr[7:0];
  assign hit_row = (pg == PAGE_LOW || pg == PAGE_HIGH) && idx < PAGE_WORDS;
  assign hit_c16 = pg == PAGE_COM16 && !idx[0] && idx <= COM16_LAST;

  // Processor writes.
  // Contents have no reset: software must initialise them.
  // Only this port changes memory; overrides never do.
  always_ff @(posedge core_clk)
  begin
    if (mem_wr && hit_row && pg == PAGE_LOW)
    begin
      low_q[idx[6:0]] <= mem_wdata;
    end
    if (mem_wr && hit_row && pg == PAGE_HIGH)
    begin
      high_q[idx[6:0]] <= mem_wdata;
    end
    if (mem_wr && hit_c16)
    begin
      c16_q[idx[6:1]] <= mem_wdata[0];
    end
  end

  // Processor reads.
  // Holes answer zero; unused bits of page 2 read zero.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mem_rdata <= 4'h0;
    end
    else if (mem_rd)
    begin
      if (hit_row && pg == PAGE_LOW)
      begin
        mem_rdata <= low_q[idx[6:0]];
      end
      else if (hit_row)
      begin
        mem_rdata <= high_q[idx[6:0]];
      end
      else if (hit_c16)
      begin
        mem_rdata <= {3'h0, c16_q[idx[6:1]]};
      end
      else
      begin
        mem_rdata <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan sequencing.
  // ----------------------------------------------------------------
  dmld_scan_timer u_timer
  (
    .core_clk             (core_clk),
    .reset                (reset),
    .low_speed_oscillator (low_speed_oscillator),
    .eighth_duty          (eighth),
    .com_step             (com_step)
  );

  // Ascending common scan.
  // Polarity flips each frame so the panel sees no net DC.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      com_q <= 5'h00;
      pol_q <= 1'b0;
    end
    else if (com_step)
    begin
      if (com_q >= last_com)
      begin
        com_q <= 5'h00;
        pol_q <= ~pol_q;
      end
      else
      begin
        com_q <= com_q + 5'h01;
      end
    end
  end

  // At 1/8 the page bit picks the source at once.
  // Otherwise commons 8-15 always read page 1.
  for (genvar s = 0; s < NUM_SEG; s++)
  begin : g_dot
    logic [3:0] lo_n;
    logic [3:0] hi_n;
    assign lo_n = low_q[2*s + {6'h00, com_q[2]}];
    assign hi_n = high_q[2*s + {6'h00, com_q[2]}];
    // Commons 8-15 are served at 1/16 and 1/17; common 16 only at 1/17.
    assign dot[s] = (com_q == 5'(LAST_COM_17)) ? c16_q[s] :
                    (com_q[3] || (eighth && display_page_select_rd)) ?
                    hi_n[com_q[1:0]] : lo_n[com_q[1:0]];
  end

  // Bias levels for the two frame polarities.
  // Selected swing is four units; everything else sees one or two.
  assign com_sel  = pol_q ? LVL_V0 : LVL_V4;
  assign com_idle = pol_q ? LVL_V3 : LVL_V1;
  assign seg_on   = pol_q ? LVL_V4 : LVL_V0;
  assign seg_off  = LVL_V2;

  // With power off every line sits at VSS.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      common_outputs <= '0;
    end
    else
    begin
      for (int c = 0; c < NUM_COM; c++)
      begin
        if (!drive_power_enable_rd)
        begin
          common_outputs[c] <= LVL_V0;
        end
        else if (c == int'(com_q))
        begin
          common_outputs[c] <= com_sel;
        end
        else
        begin
          common_outputs[c] <= com_idle;
        end
      end
    end
  end

  // All-on is tested first, so it beats all-off.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      segment_outputs <= '0;
    end
    else
    begin
      for (int s = 0; s < NUM_SEG; s++)
      begin
        if (!drive_power_enable_rd)
        begin
          segment_outputs[s] <= LVL_V0;
        end
        else if (all_dots_on_rd)
        begin
          segment_outputs[s] <= seg_on;
        end
        else if (all_dots_off_rd || !dot[s])
        begin
          segment_outputs[s] <= seg_off;
        end
        else
        begin
          segment_outputs[s] <= seg_on;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive voltage generator control.
  // ----------------------------------------------------------------

  // Sixteen contrast steps, code 15 darkest.
  // Reference is two units; others are one, three, four units.
  // Generator off forces every level to zero.
  assign unit = {3'h0, contrast_code_rd} + 7'h01;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      drive_gen_on          <= 1'b0;
      level_vc1             <= 7'h00;
      reference_drive_level <= 7'h00;
      level_vc4             <= 7'h00;
      level_vc5             <= 7'h00;
    end
    else
    begin
      drive_gen_on          <= drive_power_enable_rd;
      level_vc1             <= drive_power_enable_rd ? unit : 7'h00;
      reference_drive_level <= drive_power_enable_rd ? 7'(unit * 2) : 7'h00;
      level_vc4             <= drive_power_enable_rd ? 7'(unit * 3) : 7'h00;
      level_vc5             <= drive_power_enable_rd ? 7'(unit * 4) : 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_all_on_segs: assert property (
    drive_power_enable_rd && all_dots_on_rd |=>
      segment_outputs[0] != LVL_V2 && segment_outputs[59] == segment_outputs[0])
    else $error("all-on did not light segments");

  a_all_off_segs: assert property (
    drive_power_enable_rd && all_dots_off_rd && !all_dots_on_rd |=>
      segment_outputs[0] == LVL_V2 && segment_outputs[59] == LVL_V2)
    else $error("all-off did not blank segments");

  a_power_off_vss: assert property (
    !drive_power_enable_rd |=>
      common_outputs == '0 && segment_outputs == '0 && level_vc5 == 7'h00)
    else $error("lines driven while power is off");

  a_com_in_range: assert property (
    com_step |=> com_q <= $past(last_com) || $past(com_q) > $past(last_com))
    else $error("common index beyond duty");

  a_com_ascend: assert property (
    com_step && com_q < last_com |=> com_q == $past(com_q) + 5'h01)
    else $error("common scan not ascending");

  a_eighth_idle: assert property (
    drive_power_enable_rd && eighth && com_q <= 5'(LAST_COM_8) ##1 !$changed(pol_q) |->
      common_outputs[8] != LVL_V4 && common_outputs[8] != LVL_V0)
    else $error("unused common selected at 1/8");

  a_levels_prop: assert property (
    drive_power_enable_rd ##1 drive_power_enable_rd |->
      level_vc4 == level_vc1 + reference_drive_level && level_vc5 == 7'(level_vc1 * 4))
    else $error("drive levels out of proportion");

  a_reset_blank: assert property (
    $past(reset) |-> all_dots_off_rd && !drive_power_enable_rd && duty_select_rd == 2'h0)
    else $error("wrong control values after reset");

  a_mem_roundtrip: assert property (
    mem_wr && hit_row ##1 mem_rd && $stable(mem_addr) |=> mem_rdata == $past(mem_wdata, 2))
    else $error("display memory readback mismatch");

  c_eighth_wrap:  cover property (eighth && com_step && com_q == 5'(LAST_COM_8));
  c_com16_active: cover property (!eighth && com_q == 5'(LAST_COM_17) && drive_power_enable_rd);
  c_page_switch:  cover property (eighth && $changed(display_page_select_rd));
  c_both_override: cover property (all_dots_on_rd && all_dots_off_rd && drive_power_enable_rd);

endmodule // dmld_core

// [sim/dmld_panel_model.sv]
// Purpose: Behavioural panel model on the common and segment lines.
// Assumes: A dot lights when its common and segment sit four levels apart.
// Notes:   Reports common 31 when no single common is selected.
`timescale 1ns/1ps

module dmld_panel_model
  import dmld_pkg::*;
(
  input  wire dmld_level_t [NUM_COM-1:0] common_outputs,
  input  wire dmld_level_t [NUM_SEG-1:0] segment_outputs,
  output logic [4:0]                     row_com,
  output logic [59:0]                    row_mask,
  output logic                           row_tick
);
  int          nsel;
  logic [4:0]  c_s;
  logic [59:0] m_s;

  // Decode 1 ns after a change, so every drive register has landed.
  // Five level decode.
  initial
  begin
    row_com = 5'h1F;
    row_mask = '0;
    row_tick = 1'b0;
    forever
    begin
      @(common_outputs or segment_outputs);
      #1;
      nsel = 0;
      c_s = 5'h1F;
      for (int c = 0; c < NUM_COM; c++)
        if (common_outputs[c] inside {LVL_V0, LVL_V4})
        begin
          nsel++;
          c_s = 5'(c);
        end
      if (nsel != 1)
        c_s = 5'h1F;
      for (int s = 0; s < NUM_SEG; s++)
        m_s[s] = (c_s != 5'h1F) && ((segment_outputs[s] ^ common_outputs[c_s]) == 3'h4);
      if (c_s !== row_com || m_s !== row_mask)
      begin
        row_com = c_s;
        row_mask = m_s;
        row_tick = ~row_tick;
      end
    end
  end

endmodule // dmld_panel_model

// [sim/dmld_core_tb.sv]
// Purpose: Self-checking bench for the dot-matrix LCD driver core.
// Assumes: Oscillator period is 6 core cycles, so frames stay short.
// Notes:   Panel rows are compared against notes queued by the test sequence.
`timescale 1ns/1ps

`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end

module dmld_core_tb
  import dmld_pkg::*;
;
  localparam int OSC_CYC = 6;
  typedef struct {int com; logic [59:0] m; int per;} dmld_note_t;

  logic core_clk, reset, osc, ctrl_write, pw, on, off, dhi, dlo, pg;
  logic [3:0] cc, mem_wdata, mem_rdata, crd;
  logic pwr, onr, offr, pgr, mem_wr, mem_rd, drive_gen_on, p_tick;
  logic [1:0] drd;
  logic [11:0] mem_addr;
  logic [6:0] lv1, lv23, lv4, lv5;
  logic [27:0] ev;
  dmld_level_t [NUM_COM-1:0] com_o;
  dmld_level_t [NUM_SEG-1:0] seg_o;
  logic [4:0] p_com;
  logic [59:0] p_mask;
  logic [3:0] bm [3][120];
  dmld_note_t q[$];
  dmld_note_t nt;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int last_cyc = 0;
  int lst;
  int per_cyc;
  wire logic [9:0] rdv = {pwr, onr, offr, drd, pgr, crd};
  wire logic [27:0] lvl = {lv1, lv23, lv4, lv5};

  dmld_core uut (
    .core_clk(core_clk), .reset(reset), .low_speed_oscillator(osc),
    .ctrl_write(ctrl_write), .drive_power_enable(pw), .all_dots_on(on),
    .all_dots_off(off), .duty_select_hi(dhi), .duty_select_lo(dlo),
    .display_page_select(pg), .contrast_code(cc), .drive_power_enable_rd(pwr),
    .all_dots_on_rd(onr), .all_dots_off_rd(offr), .duty_select_rd(drd),
    .display_page_select_rd(pgr), .contrast_code_rd(crd), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .drive_gen_on(drive_gen_on), .level_vc1(lv1), .reference_drive_level(lv23),
    .level_vc4(lv4), .level_vc5(lv5), .common_outputs(com_o), .segment_outputs(seg_o)
  );

  dmld_panel_model panel (
    .common_outputs(com_o), .segment_outputs(seg_o),
    .row_com(p_com), .row_mask(p_mask), .row_tick(p_tick)
  );

  // Core clock, and a free running oscillator at an unrelated phase.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    osc = 1'b0;
    #7;
    forever #150 osc = ~osc;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  // --------
  // Monitor: each panel row takes the oldest note off the queue.
  // --------
  always @(p_tick)
  begin
    if (q.size() > 0)
    begin
      nt = q.pop_front();
      `CHK("row common", 5'(nt.com), p_com)
      `CHK("row dots", nt.m, p_mask)
      if (nt.per != 0) `CHK("row period", nt.per, cyc - last_cyc)
    end
    last_cyc = cyc;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail_wait();
    n_errors++;
    $display("MISMATCH wait exp done got timeout");
    print_verdict();
  endtask

  task automatic ctl(input logic p, a, f, input logic [1:0] d, input logic g,
                     input logic [3:0] c);
    @(negedge core_clk);
    {pw, on, off, dhi, dlo, pg, cc} = {p, a, f, d, g, c};
    ctrl_write = 1'b1;
    @(negedge core_clk);
    ctrl_write = 1'b0;
  endtask

  // Waits for the start of row c; a mid-row redraw of c does not count.
  task automatic wait_row(input int c);
    logic t;
    logic [4:0] pc;
    int i;
    t = p_tick;
    pc = p_com;
    for (i = 0; i < 20000; i++)
    begin
      @(negedge core_clk);
      if (p_tick !== t)
      begin
        t = p_tick;
        if (p_com == 5'(c) && pc != 5'(c)) break;
        pc = p_com;
      end
    end
    if (i == 20000) fail_wait();
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 20000 && q.size() > 0; i++)
      @(negedge core_clk);
    if (q.size() > 0) fail_wait();
  endtask

  function automatic logic [59:0] expm(input int c, input logic eight, g);
    int p, r;
    logic [59:0] m;
    p = eight ? int'(g) : c / 8;
    r = eight ? c : c % 8;
    for (int s = 0; s < 60; s++)
      m[s] = bm[p][s*2 + r/4][r%4];
    return m;
  endfunction

  // Writes random data to every mapped place, or reads all back.
  task automatic mem_pass(input bit wr);
    logic [3:0] w;
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < 120; i += (p == 2) ? 2 : 1)
      begin
        @(negedge core_clk);
        mem_addr = {4'(p), 8'(i)};
        if (wr)
        begin
          w = 4'($urandom());
          bm[p][i] = (p == 2) ? {3'h0, w[0]} : w;
          mem_wdata = w;
          mem_wr = 1'b1;
        end
        else
        begin
          mem_rd = 1'b1;
          @(negedge core_clk);
          mem_rd = 1'b0;
          `CHK("mem read", bm[p][i], mem_rdata)
        end
      end
    @(negedge core_clk);
    mem_wr = 1'b0;
  endtask

  // Mid-row control change; the new row must show within two cycles.
  task automatic step(input logic [59:0] m, input logic a, f);
    q.push_back('{3, m, 0});
    ctl(1'b1, a, f, 2'h2, 1'b0, 4'h7);
    repeat (2) @(negedge core_clk);
    `CHK("applied in time", 0, q.size())
    `CHK("ctrl rd", {1'b1, a, f, 2'h2, 1'b0, 4'h7}, rdv)
  endtask

  // --------
  // Main sequence.
  // --------
  initial
  begin
    {reset, ctrl_write, mem_wr, mem_rd} = 4'h8;
    {pw, on, off, dhi, dlo, pg, cc, mem_addr, mem_wdata} = '0;
    void'($urandom(32'h4d18d06b));
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    `CHK("reset ctrl", {3'b001, RST_DUTY, RST_PAGE, RST_CONTRAST}, rdv)
    `CHK("reset commons", '0, com_o)
    $display("TEST reset done");
    mem_pass(1'b1);
    mem_pass(1'b0);
    // Back to back write and read of one nibble, so the readback is exercised.
    bm[1][5] = ~bm[1][5];
    @(negedge core_clk);
    {mem_addr, mem_wdata, mem_wr} = {12'h105, bm[1][5], 1'b1};
    @(negedge core_clk);
    {mem_wr, mem_rd} = 2'b01;
    @(negedge core_clk);
    mem_rd = 1'b0;
    `CHK("mem roundtrip", bm[1][5], mem_rdata)
    $display("TEST memory done");
    for (int c = 0; c < 16; c++)
    begin
      ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 4'(c));
      @(negedge core_clk);
      ev = {7'(c + 1), 7'(2 * c + 2), 7'(3 * c + 3), 7'(4 * c + 4)};
      `CHK("contrast rd", 4'(c), crd)
      `CHK("levels", ev, lvl)
      `CHK("generator on", 1'b1, drive_gen_on)
    end
    $display("TEST contrast done");
    // Every duty code; page select set at 1/16 must change nothing.
    for (int k = 0; k < 4; k++)
    begin
      lst = (k < 2) ? 16 - k : 7;
      per_cyc = OSC_CYC * ((k < 2) ? COM_TICKS_WIDE : COM_TICKS_EIGHT);
      ctl(1'b1, 1'b0, 1'b0, 2'(k), k[0], 4'h7);
      wait_row(lst);
      for (int c = 0; c <= lst; c++)
        q.push_back('{c, expm(c, k[1], k[0]), per_cyc});
      drain();
      `CHK("duty rd", 2'(k), drd)
      `CHK("page rd", k[0], pgr)
      $display("TEST frame duty code %0d done", k);
    end
    wait_row(3);
    step(expm(3, 1'b1, 1'b0), 1'b0, 1'b0);
    step('1, 1'b1, 1'b0);
    step('0, 1'b0, 1'b1);
    step('1, 1'b1, 1'b1);
    step(expm(3, 1'b1, 1'b0), 1'b0, 1'b0);
    mem_pass(1'b0);
    $display("TEST overrides done");
    ctl(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 4'h7);
    @(negedge core_clk);
    `CHK("generator off", 1'b0, drive_gen_on)
    `CHK("levels off", 28'h0, lvl)
    `CHK("segments off", '0, seg_o)
    $display("TEST power off done");
    print_verdict();
  end

endmodule // dmld_core_tb
